// File: design/frfm_top.sv
// fault record, soft-start blanking and status pin flag masking
//
// Behaviour
// - shutdown fault code into record low nibble
// - preceding fault code into record high nibble
// - soft start ignores flags with blank bit
// - blank register A bit map for faults
// - blank register B bit0 blanks fast overcurrent
// - power good uses only unmasked flags
// - power good mask bit map
// - line status uses only unmasked flags
// - line status mask bit map
// - both pin edges debounced, four settings
`timescale 1ns/100ps
`default_nettype none
module frfm_top
    import frfm_pkg::*;
#(
    parameter int unsigned CNT_W = DEB_CNT_W,
    parameter int unsigned CYC_A = DEB_A_CYC,
    parameter int unsigned CYC_B = DEB_B_CYC,
    parameter int unsigned CYC_C = DEB_C_CYC
) (
    // clock, reset, enable
    input  wire logic             clk,
    input  wire logic             sys_rst,
    input  wire logic             ce,
    // management register port
    input  wire frfm_bus_t        bus,
    output var  logic [7:0]       rdata_reg,
    output var  logic             rvalid_reg,
    // protection flags from the detectors
    input  wire frfm_fault_t      faults,
    input  wire logic             input_off_flag,
    input  wire logic             softstart_active,
    input  wire logic             restart_req,
    // status flags for the pins
    input  wire frfm_pg_flags_t   pg_flags,
    input  wire frfm_line_flags_t line_flags,
    // outputs
    output var  logic             shutdown_reg,
    output var  logic             input_off_trip_reg,
    output var  logic             power_good_pin,
    output var  logic             line_status_pin
);

    // pick the lowest code among set bits, CODE_NONE when empty;
    // the scan runs downward so the last hit is the lowest index,
    // and faults raised in one cycle resolve to the smaller code
    function automatic logic [3:0] lowest_code(
        input logic [NUM_FAULTS-1:0] v
    );
        logic [3:0] c;
        c = CODE_NONE;
        for (int i = NUM_FAULTS - 1; i >= 0; i--) begin
            if (v[i]) begin
                c = 4'(i + 1);
            end
        end
        return c;
    endfunction : lowest_code

    // configuration registers, all cleared by reset;
    // the debounce selectors live in the same set
    logic [7:0] blank_a_reg;
    logic [7:0] blank_a_next;
    logic [7:0] blank_b_reg;
    logic [7:0] blank_b_next;
    logic [7:0] pg_mask_reg;
    logic [7:0] pg_mask_next;
    logic [7:0] line_mask_reg;
    logic [7:0] line_mask_next;
    logic [7:0] debounce_reg;
    logic [7:0] debounce_next;
    logic [7:0] rdata_next;
    logic       rvalid_next;

    // record state; eff_prev_reg holds last cycle's live faults,
    // so an onset is a fault live now and not before
    frfm_state_t     state_reg;
    frfm_state_t     state_next;
    logic [7:0]      record_reg;
    logic [7:0]      record_next;
    logic [3:0]      last_code_reg;
    logic [3:0]      last_code_next;
    frfm_fault_t     eff_prev_reg;
    frfm_fault_t     eff_prev_next;
    logic            shutdown_next;
    logic            input_off_trip_next;

    // combinational helpers, none of them registered;
    // they feed the capture stage and the pin filters
    frfm_fault_t           blank_vec;
    frfm_fault_t           eff;
    logic [NUM_FAULTS-1:0] rise;
    logic                  pg_raw_ok;
    logic                  line_raw_ok;

    // management writes; the record address has no write path and
    // unmapped addresses drop the write without any answer
    always_comb begin
        blank_a_next   = blank_a_reg;
        blank_b_next   = blank_b_reg;
        pg_mask_next   = pg_mask_reg;
        line_mask_next = line_mask_reg;
        debounce_next  = debounce_reg;

        if (bus.wr) begin
            case (bus.addr)
                ADDR_BLANK_A:   blank_a_next   = bus.wdata;
                ADDR_BLANK_B:   blank_b_next   = bus.wdata;
                ADDR_PG_MASK:   pg_mask_next   = bus.wdata;
                ADDR_LINE_MASK: line_mask_next = bus.wdata;
                ADDR_DEBOUNCE:  debounce_next  = bus.wdata;
                default:        ;
            endcase
        end
    end

    // read data lands one cycle after the strobe; unmapped reads zero
    // data holds between reads so a late sample still sees it
    always_comb begin
        rdata_next  = rdata_reg;
        rvalid_next = bus.rd;

        if (bus.rd) begin
            case (bus.addr)
                ADDR_RECORD:    rdata_next = record_reg;
                ADDR_BLANK_A:   rdata_next = blank_a_reg;
                ADDR_BLANK_B:   rdata_next = blank_b_reg;
                ADDR_PG_MASK:   rdata_next = pg_mask_reg;
                ADDR_LINE_MASK: rdata_next = line_mask_reg;
                ADDR_DEBOUNCE:  rdata_next = debounce_reg;
                default:        rdata_next = RST_RDATA;
            endcase
        end
    end

    // register stage for the management port; masks clear at reset,
    // so every flag is checked and none blanked until software says so
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            blank_a_reg   <= RST_MASK;
            blank_b_reg   <= RST_MASK;
            pg_mask_reg   <= RST_MASK;
            line_mask_reg <= RST_MASK;
            debounce_reg  <= RST_DEBOUNCE;
            rdata_reg     <= RST_RDATA;
            rvalid_reg    <= 1'b0;
        end else if (ce) begin
            blank_a_reg   <= blank_a_next;
            blank_b_reg   <= blank_b_next;
            pg_mask_reg   <= pg_mask_next;
            line_mask_reg <= line_mask_next;
            debounce_reg  <= debounce_next;
            rdata_reg     <= rdata_next;
            rvalid_reg    <= rvalid_next;
        end
    end

    // blank vector from the two soft-start registers; input off has
    // no code, so its blank bit acts on the trip path instead, and the
    // two supply overvoltage faults and input undervoltage have no blank bit at all
    always_comb begin
        blank_vec = '0;

        blank_vec.fast_overvoltage_fault    = blank_a_reg[BA_FAST_OV];
        blank_vec.overload_fault            = blank_a_reg[BA_OVERLOAD];
        blank_vec.input_overcurrent_fault   = blank_a_reg[BA_IN_OC];
        blank_vec.input_overvoltage_fault   = blank_a_reg[BA_IN_OV];
        blank_vec.overtemperature_fault     = blank_a_reg[BA_OT];
        blank_vec.output_undervoltage_fault = blank_a_reg[BA_OUT_UV];
        blank_vec.output_overvoltage_fault  = blank_a_reg[BA_OUT_OV];
        blank_vec.fast_overcurrent_fault    = blank_b_reg[BB_FAST_OC];
    end

    // blanking only while soft start runs
    // a fault held through soft start shows as an onset once blanking
    // ends or its blank bit is cleared, and may then trip at once
    always_comb begin
        eff  = softstart_active ? (faults & ~blank_vec) : faults;
        rise = eff & ~eff_prev_reg;
    end

    // capture machine: first live fault trips and freezes the record;
    // capture works on levels, so a fault still standing when restart
    // is asked for trips again on the edge after the rearm
    always_comb begin
        state_next     = state_reg;
        record_next    = record_reg;
        shutdown_next  = shutdown_reg;
        eff_prev_next  = eff;
        last_code_next = last_code_reg;

        // input off blanked, carries no code
        input_off_trip_next = input_off_flag &
            ~(softstart_active & blank_a_reg[BA_IN_OFF]);

        // newest fault onset, the candidate for the preceding code
        if (|rise) begin
            last_code_next = lowest_code(rise);
        end

        case (state_reg)
            ST_ARMED: begin
                if (|eff) begin
                    state_next    = ST_CAPTURED;
                    shutdown_next = 1'b1;
                    // shutdown cause, lowest code wins a tie
                    record_next[REC_CUR_LSB +: 4] = lowest_code(eff);
                    // fault seen just before the cause
                    record_next[REC_PREV_LSB +: 4] = last_code_reg;
                end
            end

            ST_CAPTURED: begin
                // record stays until the next capture overwrites it
                if (restart_req) begin
                    state_next    = ST_ARMED;
                    shutdown_next = 1'b0;
                end
            end

            // an unused code rearms rather than hangs
            default: begin
                state_next    = ST_ARMED;
                shutdown_next = 1'b0;
            end
        endcase
    end

    // register stage for the record; record clears to zero
    // and the onset tracker forgets any fault seen before reset
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_reg          <= ST_ARMED;
            record_reg         <= {CODE_NONE, CODE_NONE};
            last_code_reg      <= CODE_NONE;
            eff_prev_reg       <= '0;
            shutdown_reg       <= 1'b0;
            input_off_trip_reg <= 1'b0;
        end else if (ce) begin
            state_reg          <= state_next;
            record_reg         <= record_next;
            last_code_reg      <= last_code_next;
            eff_prev_reg       <= eff_prev_next;
            shutdown_reg       <= shutdown_next;
            input_off_trip_reg <= input_off_trip_next;
        end
    end

    // pin decisions from unmasked flags only; with every mask bit set
    // a pin reads good whatever the flags, so a careless mask hides
    // real faults from the host
    always_comb begin
        pg_raw_ok   = ~|(pg_flags & ~pg_mask_reg);

        line_raw_ok = ~|(line_flags & ~line_mask_reg);
    end

    // power good pin filter
    // counters are wide enough for the longest hold at the system clock
    frfm_debounce #(
        .CNT_W (CNT_W),
        .CYC_A (CYC_A),
        .CYC_B (CYC_B),
        .CYC_C (CYC_C)
    ) u_pg_deb (
        .clk      (clk),
        .sys_rst  (sys_rst),
        .ce       (ce),
        .raw_ok   (pg_raw_ok),
        .rise_sel (debounce_reg[DEB_PG_RISE +: 2]),
        .fall_sel (debounce_reg[DEB_PG_FALL +: 2]),
        .pin_reg  (power_good_pin)
    );

    // line status pin filter, same encoding; its four selector bits
    // share the register with the power good pair
    frfm_debounce #(
        .CNT_W (CNT_W),
        .CYC_A (CYC_A),
        .CYC_B (CYC_B),
        .CYC_C (CYC_C)
    ) u_line_deb (
        .clk      (clk),
        .sys_rst  (sys_rst),
        .ce       (ce),
        .raw_ok   (line_raw_ok),
        .rise_sel (debounce_reg[DEB_LINE_RISE +: 2]),
        .fall_sel (debounce_reg[DEB_LINE_FALL +: 2]),
        .pin_reg  (line_status_pin)
    );

endmodule : frfm_top
`default_nettype wire

// File: design/frfm_pkg.sv
// constants, register map and flag carriers for the fault record block
package frfm_pkg;

    // clock rate and debounce times
    localparam int unsigned CLK_KHZ     = 200_000;
    localparam int unsigned DEB_A_MS    = 200;
    localparam int unsigned DEB_B_MS    = 320;
    localparam int unsigned DEB_C_MS    = 600;
    localparam int unsigned DEB_A_CYC   = DEB_A_MS * CLK_KHZ;
    localparam int unsigned DEB_B_CYC   = DEB_B_MS * CLK_KHZ;
    localparam int unsigned DEB_C_CYC   = DEB_C_MS * CLK_KHZ;
    localparam int unsigned DEB_CNT_W   = 32;

    // debounce selector codes
    localparam logic [1:0] DEB_SEL_NONE = 2'h0;
    localparam logic [1:0] DEB_SEL_A    = 2'h1;
    localparam logic [1:0] DEB_SEL_B    = 2'h2;

    // register addresses on the management port
    localparam logic [15:0] ADDR_DEBOUNCE  = 16'hFE05;
    localparam logic [15:0] ADDR_RECORD    = 16'hFE07;
    localparam logic [15:0] ADDR_BLANK_A   = 16'hFE08;
    localparam logic [15:0] ADDR_BLANK_B   = 16'hFE09;
    localparam logic [15:0] ADDR_PG_MASK   = 16'hFE0A;
    localparam logic [15:0] ADDR_LINE_MASK = 16'hFE0B;

    // reset values
    localparam logic [7:0] RST_MASK     = 8'h00;
    localparam logic [7:0] RST_DEBOUNCE = 8'h00;
    localparam logic [7:0] RST_RDATA    = 8'h00;
    localparam logic [3:0] CODE_NONE    = 4'h0;

    // field positions
    localparam int REC_CUR_LSB    = 0;
    localparam int REC_PREV_LSB   = 4;
    localparam int DEB_PG_FALL    = 0;
    localparam int DEB_PG_RISE    = 2;
    localparam int DEB_LINE_FALL  = 4;
    localparam int DEB_LINE_RISE  = 6;
    localparam int BA_FAST_OV     = 7;
    localparam int BA_OVERLOAD    = 6;
    localparam int BA_IN_OC       = 5;
    localparam int BA_IN_OFF      = 4;
    localparam int BA_IN_OV       = 3;
    localparam int BA_OT          = 2;
    localparam int BA_OUT_UV      = 1;
    localparam int BA_OUT_OV      = 0;
    localparam int BB_FAST_OC     = 0;
    localparam int NUM_FAULTS     = 11;

    // coded faults, bit index is the fault code minus one
    typedef struct packed {
        logic core_2v5_overvoltage_fault;
        logic supply_3v3_overvoltage_fault;
        logic fast_overcurrent_fault;
        logic fast_overvoltage_fault;
        logic overload_fault;
        logic input_overcurrent_fault;
        logic input_undervoltage_fault;
        logic input_overvoltage_fault;
        logic overtemperature_fault;
        logic output_undervoltage_fault;
        logic output_overvoltage_fault;
    } frfm_fault_t;

    // flags checked for power good, in mask bit order
    typedef struct packed {
        logic output_undervoltage_fault;
        logic output_overvoltage_warning;
        logic fast_overvoltage_fault;
        logic overload_fault;
        logic fast_overcurrent_fault;
        logic input_overcurrent_fault;
        logic overtemperature_fault;
        logic fast_loop_flag;
    } frfm_pg_flags_t;

    // flags checked for line status, in mask bit order
    typedef struct packed {
        logic input_undervoltage_fault;
        logic input_undervoltage_warning;
        logic input_overcurrent_fault;
        logic input_overcurrent_warning;
        logic fast_overcurrent_fault;
        logic line_period_error_flag;
        logic brownout_flag;
        logic inrush_flag;
    } frfm_line_flags_t;

    // management port request
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [15:0] addr;
        logic [7:0]  wdata;
    } frfm_bus_t;

    // record state machine
    typedef enum logic [1:0] {
        ST_ARMED    = 2'b01,
        ST_CAPTURED = 2'b10
    } frfm_state_t;

endpackage : frfm_pkg

// File: design/frfm_debounce.sv
// two-way debounce filter for one status pin
`timescale 1ns/100ps
`default_nettype none
module frfm_debounce
    import frfm_pkg::*;
#(
    parameter int unsigned CNT_W = DEB_CNT_W,
    parameter int unsigned CYC_A = DEB_A_CYC,
    parameter int unsigned CYC_B = DEB_B_CYC,
    parameter int unsigned CYC_C = DEB_C_CYC
) (
    // clock and reset
    input  wire logic       clk,
    input  wire logic       sys_rst,
    input  wire logic       ce,
    // level and settings
    input  wire logic       raw_ok,
    input  wire logic [1:0] rise_sel,
    input  wire logic [1:0] fall_sel,
    // filtered level
    output var  logic       pin_reg
);

    logic [CNT_W-1:0] cnt_reg;
    logic [CNT_W-1:0] cnt_next;
    logic             pin_next;
    logic [1:0]       sel;
    logic [CNT_W-1:0] target;

    // hold time for the pending direction; zero flips on the next edge
    always_comb begin
        sel = pin_reg ? fall_sel : rise_sel;
        case (sel)
            DEB_SEL_NONE: target = '0;
            DEB_SEL_A:    target = CNT_W'(CYC_A - 1);
            DEB_SEL_B:    target = CNT_W'(CYC_B - 1);
            default:      target = CNT_W'(CYC_C - 1);
        endcase
    end

    // count while the input disagrees, restart on any agreement
    always_comb begin
        pin_next = pin_reg;
        cnt_next = '0;
        if (raw_ok != pin_reg) begin
            if (cnt_reg >= target) begin
                pin_next = raw_ok;
            end else begin
                cnt_next = cnt_reg + CNT_W'(1);
            end
        end
    end

    // registers; pin shows not-ok from reset
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            cnt_reg <= '0;
            pin_reg <= 1'b0;
        end else if (ce) begin
            cnt_reg <= cnt_next;
            pin_reg <= pin_next;
        end
    end

endmodule : frfm_debounce
`default_nettype wire

// File: bench/frfm_monitor.sv
// port assertions for the fault record and flag masking block
`timescale 1ns/100ps
`default_nettype none
module frfm_monitor
    import frfm_pkg::*;
(
    // clock and reset
    input wire logic        clk,
    input wire logic        sys_rst,
    input wire logic        ce,
    // register port
    input wire frfm_bus_t   bus,
    input wire logic [7:0]  rdata_reg,
    input wire logic        rvalid_reg,
    // protection side
    input wire frfm_fault_t faults,
    input wire logic        input_off_flag,
    input wire logic        softstart_active,
    input wire logic        restart_req,
    input wire logic        shutdown_reg,
    input wire logic        input_off_trip_reg,
    input wire logic        power_good_pin
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    // a read taken, and an armed record meeting an unblanked fault
    sequence s_read;
        ce && bus.rd;
    endsequence
    sequence s_arm_trip;
        ce && !shutdown_reg && !softstart_active && (|faults);
    endsequence

    a_read_answer:
        assert property (s_read |=> rvalid_reg)
        else $error("read got no answer");
    a_no_stray_valid:
        assert property (ce && !bus.rd |=> !rvalid_reg)
        else $error("answer without a read");
    a_rdata_holds:
        assert property (ce && !bus.rd |=> $stable(rdata_reg))
        else $error("read data moved without a read");
    a_unmapped_zero:
        assert property (s_read ##0 bus.addr == 16'hFE06 |=> rdata_reg == 8'h00)
        else $error("unmapped read not zero");
    a_fault_trips:
        assert property (s_arm_trip |=> shutdown_reg)
        else $error("fault did not shut down");
    a_shutdown_holds:
        assert property (ce && shutdown_reg && !restart_req |=> shutdown_reg)
        else $error("shutdown dropped without restart");
    a_restart_clears:
        assert property (ce && shutdown_reg && restart_req |=> !shutdown_reg)
        else $error("restart did not rearm");
    a_trip_follows:
        assert property (ce && !softstart_active
                         |=> input_off_trip_reg == $past(input_off_flag))
        else $error("input off trip wrong outside soft start");
    a_ce_freezes:
        assert property (!ce |=> $stable(rdata_reg) && $stable(shutdown_reg)
                         && $stable(power_good_pin))
        else $error("state moved with enable low");
endmodule : frfm_monitor

bind frfm_top frfm_monitor i_frfm_monitor (
    .clk(clk), .sys_rst(sys_rst), .ce(ce), .bus(bus),
    .rdata_reg(rdata_reg), .rvalid_reg(rvalid_reg), .faults(faults),
    .input_off_flag(input_off_flag), .softstart_active(softstart_active),
    .restart_req(restart_req), .shutdown_reg(shutdown_reg),
    .input_off_trip_reg(input_off_trip_reg), .power_good_pin(power_good_pin)
);
`default_nettype wire

// File: bench/frfm_supply_model.sv
// supply side model: protection levels and status pin flags
`timescale 1ns/100ps
`default_nettype none
module frfm_supply_model
    import frfm_pkg::*;
(
    // clock
    input  wire logic             clk,
    // levels toward the block
    output var  frfm_fault_t      faults,
    output var  logic             input_off_flag,
    output var  logic             softstart_active,
    output var  logic             restart_req,
    output var  frfm_pg_flags_t   pg_flags,
    output var  frfm_line_flags_t line_flags
);
    // healthy supply, soft start finished
    initial begin
        faults = '0;
        input_off_flag = 1'b0;
        softstart_active = 1'b0;
        restart_req = 1'b0;
        pg_flags = '0;
        line_flags = '0;
    end

    // levels change just after a falling edge, never on the sampling edge
    task automatic set_prot(input frfm_fault_t f, input logic off,
                            input logic ss);
        @(negedge clk);
        faults = f;
        input_off_flag = off;
        softstart_active = ss;
    endtask : set_prot

    task automatic set_flags(input frfm_pg_flags_t p,
                             input frfm_line_flags_t l);
        @(negedge clk);
        pg_flags = p;
        line_flags = l;
    endtask : set_flags

    // one cycle restart request
    task automatic restart();
        @(negedge clk);
        restart_req = 1'b1;
        @(negedge clk);
        restart_req = 1'b0;
    endtask : restart
endmodule : frfm_supply_model
`default_nettype wire

// File: bench/tb_top.sv
// self-checking bench for the fault record and flag masking block
`timescale 1ns/100ps
`default_nettype none
module tb_top
    import frfm_pkg::*;
;
    logic             clk, sys_rst, ce;
    frfm_bus_t        bus;
    logic [7:0]       rdata_reg, got, d;
    logic             rvalid_reg, shutdown_reg, input_off_trip_reg;
    logic             power_good_pin, line_status_pin, input_off_flag;
    logic             softstart_active, restart_req;
    frfm_fault_t      faults;
    frfm_pg_flags_t   pg_flags, pgf;
    frfm_line_flags_t line_flags, lnf;
    logic [15:0]      ba;
    logic [3:0]       prev;
    int               n_mismatch = 0, n_checks = 0, cycles = 0;
    int               cyc [4] = '{0, 4, 8, 12};
    int               bb  [8] = '{7, 6, 5, 3, 2, 1, 0, 0};
    int               bc  [8] = '{8, 7, 6, 4, 3, 2, 1, 9};
    wire logic [7:0]  pins = {6'h00, power_good_pin, line_status_pin};
    wire logic [7:0]  trip = {6'h00, shutdown_reg, input_off_trip_reg};

    // short debounce counts keep the run brief
    frfm_top #(.CYC_A(4), .CYC_B(8), .CYC_C(12)) i_frfm_top (
        .clk(clk), .sys_rst(sys_rst), .ce(ce), .bus(bus),
        .rdata_reg(rdata_reg), .rvalid_reg(rvalid_reg), .faults(faults),
        .input_off_flag(input_off_flag), .softstart_active(softstart_active),
        .restart_req(restart_req), .pg_flags(pg_flags),
        .line_flags(line_flags), .shutdown_reg(shutdown_reg),
        .input_off_trip_reg(input_off_trip_reg),
        .power_good_pin(power_good_pin), .line_status_pin(line_status_pin));
    frfm_supply_model i_frfm_supply_model (
        .clk(clk), .faults(faults), .input_off_flag(input_off_flag),
        .softstart_active(softstart_active), .restart_req(restart_req),
        .pg_flags(pg_flags), .line_flags(line_flags));

    task automatic test_done();
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : test_done

    task automatic check(input logic [7:0] g, input logic [7:0] e);
        n_checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, g, e);
        end
    endtask : check

    task automatic wait_n(input int n);
        repeat (n) @(negedge clk);
    endtask : wait_n

    // one write, taken at the next rising edge
    task automatic wr(input logic [15:0] a, input logic [7:0] v);
        @(negedge clk);
        bus = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v};
        @(negedge clk);
        bus = '0;
    endtask : wr

    // answer stands just after the taking edge, checked at the next falling edge
    task automatic rd(input logic [15:0] a, output logic [7:0] v);
        @(negedge clk);
        bus = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(negedge clk);
        bus = '0;
        check({7'h00, rvalid_reg}, 8'h01);
        v = rdata_reg;
    endtask : rd

    // 200 MHz clock
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    // watchdog against a hang
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            n_mismatch++;
            test_done();
        end
    end

    initial begin
        sys_rst = 1'b1;
        ce = 1'b1;
        bus = '0;
        wait_n(8);
        sys_rst = 1'b0;
        // registers come up clear, the unmapped hole reads zero
        for (int a = 5; a < 12; a++) begin
            rd(16'hFE00 + a[15:0], got);
            check(got, 8'h00);
        end
        wr(ADDR_RECORD, 8'hFF);
        rd(ADDR_RECORD, got);
        check(got, 8'h00);
        for (int a = 8; a < 12; a++) begin
            d = (a == 9) ? 8'h01 : 8'h50 + a[7:0];
            wr(16'hFE00 + a[15:0], d);
            rd(16'hFE00 + a[15:0], got);
            check(got, d);
            wr(16'hFE00 + a[15:0], 8'h00);
        end
        // field names pin the warning and period flags to bits 6 and 2
        pgf = '0;
        pgf.output_overvoltage_warning = 1'b1;
        lnf = '0;
        lnf.line_period_error_flag = 1'b1;
        i_frfm_supply_model.set_flags(pgf, lnf);
        wr(ADDR_PG_MASK, 8'h40);
        wr(ADDR_LINE_MASK, 8'h04);
        wait_n(2);
        check(pins, 8'h03);
        wr(ADDR_PG_MASK, 8'hBF);
        wr(ADDR_LINE_MASK, 8'hFB);
        wait_n(2);
        check(pins, 8'h00);
        // each flag drops its pin until masked
        for (int i = 0; i < 8; i++) begin
            i_frfm_supply_model.set_flags(8'h01 << i, 8'h01 << i);
            wr(ADDR_PG_MASK, 8'h00);
            wr(ADDR_LINE_MASK, 8'h00);
            wait_n(2);
            check(pins, 8'h00);
            wr(ADDR_PG_MASK, 8'h01 << i);
            wr(ADDR_LINE_MASK, 8'h01 << i);
            wait_n(2);
            check(pins, 8'h03);
        end
        i_frfm_supply_model.set_flags('0, '0);
        // every nonzero debounce setting, both edges, one-cycle glitch refused
        for (int s = 1; s < 4; s++) begin
            wr(ADDR_DEBOUNCE, {4{s[1:0]}});
            i_frfm_supply_model.set_flags(8'h10, 8'h10);
            i_frfm_supply_model.set_flags('0, '0);
            wait_n(cyc[s] + 3);
            check(pins, 8'h03);
            i_frfm_supply_model.set_flags(8'h10, 8'h10);
            wait_n(cyc[s] - 1);
            check(pins, 8'h03);
            wait_n(4);
            check(pins, 8'h00);
            i_frfm_supply_model.set_flags('0, '0);
            wait_n(cyc[s] - 1);
            check(pins, 8'h00);
            wait_n(4);
            check(pins, 8'h03);
        end
        // only the power good rise is slow: pins split apart
        wr(ADDR_DEBOUNCE, 8'h0C);
        i_frfm_supply_model.set_flags(8'h10, 8'h10);
        i_frfm_supply_model.set_flags('0, '0);
        wait_n(2);
        check(pins, 8'h01);
        // every code captured, previous onset kept beside it
        prev = 4'h0;
        for (int k = 1; k <= NUM_FAULTS; k++) begin
            i_frfm_supply_model.set_prot(11'h001 << (k - 1), 1'b0, 1'b0);
            wait_n(2);
            rd(ADDR_RECORD, got);
            check(got, {prev, k[3:0]});
            i_frfm_supply_model.set_prot('0, 1'b0, 1'b0);
            i_frfm_supply_model.restart();
            prev = k[3:0];
        end
        // simultaneous faults report the lowest code
        i_frfm_supply_model.set_prot(11'h108, 1'b0, 1'b0);
        wait_n(2);
        rd(ADDR_RECORD, got);
        check(got, 8'hB4);
        i_frfm_supply_model.set_prot('0, 1'b0, 1'b0);
        i_frfm_supply_model.restart();
        // a blanked fault is held off in soft start, trips once its blank bit clears
        for (int i = 0; i < 8; i++) begin
            ba = (i < 7) ? ADDR_BLANK_A : ADDR_BLANK_B;
            wr(ba, 8'h01 << bb[i]);
            i_frfm_supply_model.set_prot(11'h001 << (bc[i] - 1), 1'b0, 1'b1);
            wait_n(3);
            check(trip, 8'h00);
            wr(ba, 8'h00);
            wait_n(2);
            rd(ADDR_RECORD, got);
            check({shutdown_reg, 3'h0, got[3:0]}, 8'h80 + bc[i]);
            i_frfm_supply_model.set_prot('0, 1'b0, 1'b0);
            i_frfm_supply_model.restart();
        end
        // unblankable input undervoltage still trips; input off blanked
        wr(ADDR_BLANK_A, 8'hFF);
        wr(ADDR_BLANK_B, 8'h01);
        i_frfm_supply_model.set_prot(11'h010, 1'b1, 1'b1);
        wait_n(2);
        check(trip, 8'h02);
        wr(ADDR_BLANK_A, 8'h00);
        wait_n(2);
        check(trip, 8'h03);
        // outside soft start the blank bits have no effect
        wr(ADDR_BLANK_A, 8'hFF);
        i_frfm_supply_model.set_prot(11'h010, 1'b1, 1'b0);
        wait_n(2);
        check(trip, 8'h03);
        // enable low freezes the shutdown across a restart request
        ce = 1'b0;
        i_frfm_supply_model.restart();
        wait_n(2);
        check(trip, 8'h03);
        ce = 1'b1;
        test_done();
    end
endmodule : tb_top
`default_nettype wire
